//--- sirm_board.sv
`timescale 1ns/1ps
`default_nettype none
module sirm_board (
  // Device pin drive
  input  wire logic rst_pin_out_n,
  input  wire logic rst_pin_oe_n,
  // Board reset button
  input  wire logic ext_low,
  // Wire level
  output logic      pin_n
);
  // Pull-up holds the wire high unless a party sinks it
  assign pin_n = ((!rst_pin_oe_n && !rst_pin_out_n) || ext_low) ? 1'b0 : 1'b1;
endmodule : sirm_board
`default_nettype wire

//--- sirm_cfg.svh
`ifndef SIRM_CFG_SVH
`define SIRM_CFG_SVH

// Register byte addresses
`define SIRM_ADDR_STATUS    12'h000
`define SIRM_ADDR_THRESH    12'h004
`define SIRM_ADDR_OPTION    12'h008
`define SIRM_ADDR_IRQ_STAT  12'h00C
`define SIRM_ADDR_IRQ_MASK  12'h010
`define SIRM_ADDR_CPU       12'h014

// Integrity status register field positions
`define SIRM_ST_WARN_IE     0
`define SIRM_ST_WARN_FLAG   1
`define SIRM_ST_UV_FLAG     2
`define SIRM_ST_WDG_FLAG    4

// Interrupt status / mask bit positions
`define SIRM_EV_WARN        0
`define SIRM_EV_UV          1
`define SIRM_EV_WDG         2
`define SIRM_EV_PIN         3

// Reset values
`define SIRM_THRESH_RST     2'h3
`define SIRM_THRESH_OFF     2'h3
`define SIRM_OPT_RST        3'h1
`define SIRM_MASK_RST       4'h0

// Timing: minimum watchdog output pulse, spike filter length
`define SIRM_CLK_NS         10
`define SIRM_WDG_PULSE_NS   20000
`define SIRM_WDG_PULSE_CYC  ((`SIRM_WDG_PULSE_NS + `SIRM_CLK_NS - 1) / `SIRM_CLK_NS)
`define SIRM_GLITCH_NS      400
`define SIRM_GLITCH_CYC     ((`SIRM_GLITCH_NS + `SIRM_CLK_NS - 1) / `SIRM_CLK_NS)

`endif

//--- sirm_filter.sv
`timescale 1ns/1ps
`default_nettype none
`include "sirm_cfg.svh"

// Three-stage synchroniser with a change accepted when stages two and three agree,
// followed by a hold filter that rejects pulses shorter than LEN cycles.
module sirm_filter #(
  parameter int LEN = 4
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic reset,
  // Raw asynchronous level and its filtered copy
  input  wire logic din,
  output var  logic dout_q
);

  logic [2:0]  sync_q;   // Synchroniser chain
  logic        agree_q;  // Agreed level
  logic [15:0] cnt_q;    // Stability counter

  wire stable_in = (sync_q[1] == sync_q[2]) ? sync_q[2] : agree_q;
  wire differs   = stable_in != dout_q;

  // Synchronise and agree
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sync_q  <= 3'h0;
      agree_q <= 1'b0;
    end else begin
      sync_q  <= {sync_q[1:0], din};
      agree_q <= stable_in;
    end
  end

  // Accept a change only after LEN steady cycles
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cnt_q  <= 16'h0000;
      dout_q <= 1'b0;
    end else if (!differs) begin
      cnt_q <= 16'h0000;
    end else if (cnt_q >= 16'(LEN - 1)) begin
      cnt_q  <= 16'h0000;
      dout_q <= stable_in;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

endmodule : sirm_filter
`default_nettype wire

//--- sirm_pkg.sv
package sirm_pkg;

  // Undervoltage threshold level option
  typedef enum logic [1:0] {
    SIRM_LVL_LOW  = 2'h0,
    SIRM_LVL_MED  = 2'h1,
    SIRM_LVL_HIGH = 2'h2
  } sirm_lvl_e;

  // Power mode of the CPU
  typedef enum logic [1:0] {
    SIRM_RUN  = 2'h0,
    SIRM_WAIT = 2'h1,
    SIRM_HALT = 2'h2
  } sirm_mode_e;

  // Reset-pin sequencer states
  typedef enum logic [1:0] {
    SIRM_IDLE = 2'h0,
    SIRM_UV   = 2'h1,
    SIRM_WDG  = 2'h2
  } sirm_st_e;

  // Analog comparator outputs
  typedef struct packed {
    logic uv_low;
    logic warn_low;
  } sirm_ana_s;

endpackage : sirm_pkg

//--- sirm_top.sv
// Implementation choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "sirm_cfg.svh"

module sirm_top (
  // Clock and reset
  input  wire logic                sys_clk,
  input  wire logic                reset,
  // APB slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output var  logic [31:0]         prdata,
  output var  logic                pready,
  output var  logic                pslverr,
  // Analog comparators and watchdog
  input  wire sirm_pkg::sirm_ana_s ana,
  input  wire logic                wdg_underflow,
  // CPU state
  input  wire logic                cpu_irq_mask,
  input  wire sirm_pkg::sirm_mode_e cpu_mode,
  input  wire logic                warn_isr_enter,
  // Shared reset pin
  input  wire logic                rst_pin_in_n,
  output var  logic                rst_pin_out_n,
  output var  logic                rst_pin_oe_n,
  // Threshold selects to the analog comparators
  output var  logic [1:0]          warn_thresh_sel,
  output var  logic [1:0]          uv_thresh_sel,
  output var  logic                warn_det_enable,
  // Requests to the CPU
  output var  logic                warn_irq_req,
  output var  logic                warn_wake,
  output var  logic                sys_reset,
  output var  logic                irq
);

  //////////////////////////////////////////////////////////////////////////////
  // Registers
  //////////////////////////////////////////////////////////////////////////////

  logic [1:0]          thresh_q;     // Warning threshold select
  logic [2:0]          opt_q;        // {uv level[1:0], uv enable}
  logic                warn_ie_q;    // Warning interrupt enable
  logic                wdg_flag_q;   // Watchdog reset flag
  logic                uv_flag_q;    // Undervoltage reset flag
  logic                pend_q;       // Pending warning request
  logic                warn_prev_q;  // Previous filtered warning level
  logic [3:0]          ev_q;         // Sticky event status
  logic [3:0]          mask_q;       // Event mask
  logic [15:0]         pulse_q;      // Watchdog pulse counter
  logic                wdg_prev_q;   // Previous watchdog underflow level
  logic                uv_prev_q;    // Previous undervoltage reset level
  logic                pin_prev_q;   // Previous pin level
  sirm_pkg::sirm_st_e  st_q;         // Pin sequencer state
  sirm_pkg::sirm_st_e  st_d;

  //////////////////////////////////////////////////////////////////////////////
  // Input conditioning
  //////////////////////////////////////////////////////////////////////////////

  logic uv_low_f;   // Filtered supply-low
  logic warn_low_f; // Filtered warning comparator
  logic pin_low_f;  // Filtered external pin low

  // Spike filter on undervoltage comparator
  sirm_filter #(.LEN(`SIRM_GLITCH_CYC)) u_uv_filt (
    .sys_clk (sys_clk),
    .reset   (reset),
    .din     (ana.uv_low),
    .dout_q  (uv_low_f)
  );

  // Warning comparator synchroniser
  sirm_filter #(.LEN(1)) u_warn_filt (
    .sys_clk (sys_clk),
    .reset   (reset),
    .din     (ana.warn_low),
    .dout_q  (warn_low_f)
  );

  // External pin synchroniser, low means reset
  sirm_filter #(.LEN(1)) u_pin_filt (
    .sys_clk (sys_clk),
    .reset   (reset),
    .din     (~rst_pin_in_n),
    .dout_q  (pin_low_f)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Decode
  //////////////////////////////////////////////////////////////////////////////

  wire apb_acc   = psel && penable;
  wire apb_wr    = apb_acc && pwrite;
  wire apb_rd    = apb_acc && !pwrite;
  wire sel_stat  = paddr == `SIRM_ADDR_STATUS;
  wire sel_thr   = paddr == `SIRM_ADDR_THRESH;
  wire sel_opt   = paddr == `SIRM_ADDR_OPTION;
  wire sel_ist   = paddr == `SIRM_ADDR_IRQ_STAT;
  wire sel_msk   = paddr == `SIRM_ADDR_IRQ_MASK;
  wire sel_cpu   = paddr == `SIRM_ADDR_CPU;
  wire unmapped  = !(sel_stat || sel_thr || sel_opt || sel_ist || sel_msk || sel_cpu);
  wire halted    = cpu_mode == sirm_pkg::SIRM_HALT;
  wire freeze    = halted;
  wire uv_en     = opt_q[0];
  wire uv_active = uv_en && uv_low_f;
  wire wdg_rise  = wdg_underflow && !wdg_prev_q;
  wire uv_rise   = uv_active && !uv_prev_q;
  wire pin_rise  = pin_low_f && !pin_prev_q;
  wire warn_off  = thresh_q == `SIRM_THRESH_OFF;
  wire warn_lvl  = warn_low_f && !warn_off;
  wire warn_edge = warn_lvl != warn_prev_q;
  wire pulse_run = pulse_q != 16'h0000;
  wire drive_low = (st_q != sirm_pkg::SIRM_IDLE) || uv_active || pulse_run;
  wire rd_stat   = apb_rd && sel_stat;
  wire [3:0] ev_set = {pin_rise, wdg_rise, uv_rise, warn_edge};
  wire [3:0] ev_clr = (apb_wr && sel_ist) ? pwdata[3:0] : 4'h0;

  wire [7:0] stat_word = {3'h0, wdg_flag_q, 1'b0, uv_flag_q, warn_lvl, warn_ie_q};

  //////////////////////////////////////////////////////////////////////////////
  // Pin sequencer
  //////////////////////////////////////////////////////////////////////////////

  // Next state: undervoltage wins over watchdog
  always_comb begin
    st_d = st_q;
    case (st_q)
      sirm_pkg::SIRM_IDLE: begin
        if (uv_active) begin
          st_d = sirm_pkg::SIRM_UV;
        end else if (wdg_rise) begin
          st_d = sirm_pkg::SIRM_WDG;
        end
      end
      sirm_pkg::SIRM_UV: begin
        if (!uv_active) begin
          st_d = sirm_pkg::SIRM_IDLE;
        end
      end
      sirm_pkg::SIRM_WDG: begin
        if (uv_active) begin
          st_d = sirm_pkg::SIRM_UV;
        end else if (pulse_q == 16'h0001) begin
          st_d = sirm_pkg::SIRM_IDLE;
        end
      end
      default: begin
        st_d = sirm_pkg::SIRM_IDLE;
      end
    endcase
  end

  // State and edge history
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      st_q       <= sirm_pkg::SIRM_IDLE;
      wdg_prev_q <= 1'b0;
      uv_prev_q  <= 1'b0;
      pin_prev_q <= 1'b0;
    end else begin
      st_q       <= st_d;
      wdg_prev_q <= wdg_underflow;
      uv_prev_q  <= uv_active;
      pin_prev_q <= pin_low_f;
    end
  end

  // Watchdog minimum pulse counter, started at the underflow
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      pulse_q <= 16'h0000;
    end else if (wdg_rise) begin
      pulse_q <= 16'(`SIRM_WDG_PULSE_CYC);
    end else if (pulse_run) begin
      pulse_q <= pulse_q - 16'h0001;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Reset-source flags
  //////////////////////////////////////////////////////////////////////////////

  // Watchdog flag: set by hw, cleared by zero write or undervoltage
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      wdg_flag_q <= 1'b0;
    end else if (uv_active) begin
      wdg_flag_q <= 1'b0;
    end else if (wdg_rise) begin
      wdg_flag_q <= 1'b1;
    end else if (apb_wr && sel_stat && !freeze && !pwdata[`SIRM_ST_WDG_FLAG]) begin
      wdg_flag_q <= 1'b0;
    end
  end

  // Undervoltage flag: set by undervoltage reset, cleared by a read
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      uv_flag_q <= 1'b0;
    end else if (uv_active) begin
      uv_flag_q <= 1'b1;
    end else if (rd_stat && !freeze) begin
      uv_flag_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Software registers
  //////////////////////////////////////////////////////////////////////////////

  // Enable, threshold, option and mask writes
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      warn_ie_q <= 1'b0;
      thresh_q  <= `SIRM_THRESH_RST;
      opt_q     <= `SIRM_OPT_RST;
      mask_q    <= `SIRM_MASK_RST;
    end else if (apb_wr) begin
      if (sel_stat && !freeze) begin
        warn_ie_q <= pwdata[`SIRM_ST_WARN_IE];
      end
      if (sel_thr) begin
        thresh_q <= pwdata[1:0];
      end
      if (sel_opt) begin
        opt_q <= pwdata[2:0];
      end
      if (sel_msk) begin
        mask_q <= pwdata[3:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Warning interrupt
  //////////////////////////////////////////////////////////////////////////////

  // Pending request: set on crossing, cleared on service entry; set wins
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      warn_prev_q <= 1'b0;
      pend_q      <= 1'b0;
    end else begin
      warn_prev_q <= warn_lvl;
      if (warn_edge && warn_ie_q) begin
        pend_q <= 1'b1;
      end else if (warn_isr_enter) begin
        pend_q <= 1'b0;
      end
    end
  end

  // Sticky event status, set beats write-one clear
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      ev_q <= 4'h0;
    end else begin
      ev_q <= (ev_q & ~ev_clr) | ev_set;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs
  //////////////////////////////////////////////////////////////////////////////

  // Registered outputs to pins, CPU and analog
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rst_pin_out_n   <= 1'b0;
      rst_pin_oe_n    <= 1'b1;
      sys_reset       <= 1'b1;
      warn_irq_req    <= 1'b0;
      warn_wake       <= 1'b0;
      irq             <= 1'b0;
      warn_thresh_sel <= `SIRM_THRESH_RST;
      uv_thresh_sel   <= 2'h0;
      warn_det_enable <= 1'b0;
    end else begin
      rst_pin_out_n   <= 1'b0;
      rst_pin_oe_n    <= !drive_low;
      sys_reset       <= drive_low || pin_low_f;
      warn_irq_req    <= pend_q && warn_ie_q && !cpu_irq_mask;
      warn_wake       <= pend_q && warn_ie_q && !halted;
      irq             <= |(ev_q & mask_q);
      warn_thresh_sel <= thresh_q;
      uv_thresh_sel   <= opt_q[2:1];
      warn_det_enable <= !warn_off;
    end
  end

  // APB answer: single-cycle access, error on unmapped
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && unmapped;
      if (psel && !penable && !pwrite) begin
        if (sel_stat) begin
          prdata <= {24'h000000, stat_word};
        end else if (sel_thr) begin
          prdata <= {30'h0, thresh_q};
        end else if (sel_opt) begin
          prdata <= {29'h0, opt_q};
        end else if (sel_ist) begin
          prdata <= {28'h0, ev_q};
        end else if (sel_msk) begin
          prdata <= {28'h0, mask_q};
        end else if (sel_cpu) begin
          prdata <= {28'h0, pend_q, halted, cpu_irq_mask, pin_low_f};
        end else begin
          prdata <= 32'h0000_0000;
        end
      end
    end
  end

endmodule : sirm_top
`default_nettype wire

//--- sirm_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////
module sirm_chk (
  // Clock and reset
  input wire logic                 sys_clk,
  input wire logic                 reset,
  // Bus handshake
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pready,
  input wire logic                 pslverr,
  // Causes
  input wire sirm_pkg::sirm_ana_s  ana,
  input wire logic                 wdg_underflow,
  input wire logic                 cpu_irq_mask,
  input wire sirm_pkg::sirm_mode_e cpu_mode,
  // Watched outputs
  input wire logic                 rst_pin_out_n,
  input wire logic                 rst_pin_oe_n,
  input wire logic [1:0]           warn_thresh_sel,
  input wire logic                 warn_det_enable,
  input wire logic                 warn_irq_req,
  input wire logic                 warn_wake
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  // Watchdog cause and the pin held low after it
  sequence wdg_cause_s; $rose(wdg_underflow); endsequence
  sequence pin_held_s; (!rst_pin_oe_n) [*8]; endsequence
  pin_od_a: assert property (rst_pin_out_n == 1'b0)
    else $error("pin data not low");
  wdg_pulse_a: assert property (wdg_cause_s |-> ##[1:2] pin_held_s)
    else $error("watchdog pulse short");
  uv_spike_a: assert property ($rose(ana.uv_low) && rst_pin_oe_n |=> rst_pin_oe_n [*8])
    else $error("spike reached pin");
  irq_masked_a: assert property (cpu_irq_mask && $past(cpu_irq_mask) |-> !warn_irq_req)
    else $error("request while masked");
  halt_wake_a: assert property (cpu_mode == sirm_pkg::SIRM_HALT
    && $past(cpu_mode) == sirm_pkg::SIRM_HALT |-> !warn_wake)
    else $error("wake in halt");
  thresh_off_a: assert property (warn_det_enable == (warn_thresh_sel != 2'h3))
    else $error("detector enable wrong");
  apb_ready_a: assert property (psel && !penable |=> pready)
    else $error("no ready in access");
  apb_pulse_a: assert property (pready |=> !pready)
    else $error("ready too long");
  err_pair_a: assert property (pslverr |-> pready)
    else $error("error without ready");
endmodule : sirm_chk

bind sirm_top sirm_chk u_chk (.sys_clk, .reset, .psel, .penable, .pready, .pslverr,
  .ana, .wdg_underflow, .cpu_irq_mask, .cpu_mode, .rst_pin_out_n, .rst_pin_oe_n,
  .warn_thresh_sel, .warn_det_enable, .warn_irq_req, .warn_wake);
`default_nettype wire

//--- testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "sirm_cfg.svh"
module testbench;
  localparam logic [11:0] A_ST = `SIRM_ADDR_STATUS;
  localparam logic [11:0] A_TH = `SIRM_ADDR_THRESH;
  localparam logic [11:0] A_OP = `SIRM_ADDR_OPTION;
  localparam logic [11:0] A_EV = `SIRM_ADDR_IRQ_STAT;
  localparam logic [11:0] A_MK = `SIRM_ADDR_IRQ_MASK;
  localparam logic [11:0] A_CP = `SIRM_ADDR_CPU;
  // Stimulus
  logic sys_clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  sirm_pkg::sirm_ana_s ana = '0;
  sirm_pkg::sirm_mode_e cpu_mode = sirm_pkg::SIRM_RUN;
  logic wdg_underflow = 1'b0, cpu_irq_mask = 1'b0, warn_isr_enter = 1'b0, ext_low = 1'b0;
  // Design outputs
  logic [31:0] prdata;
  logic pready, pslverr, pin_n, rst_pin_out_n, rst_pin_oe_n, warn_det_enable;
  logic [1:0] warn_thresh_sel, uv_thresh_sel;
  logic warn_irq_req, warn_wake, sys_reset, irq;
  int errors = 0, checks = 0, cyc = 0;
  always #5 sys_clk = ~sys_clk;
  sirm_top dut (.sys_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .ana, .wdg_underflow, .cpu_irq_mask, .cpu_mode, .warn_isr_enter,
    .rst_pin_in_n(pin_n), .rst_pin_out_n, .rst_pin_oe_n, .warn_thresh_sel,
    .uv_thresh_sel, .warn_det_enable, .warn_irq_req, .warn_wake, .sys_reset, .irq);
  sirm_board board (.rst_pin_out_n, .rst_pin_oe_n, .ext_low, .pin_n);
  ////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_sim
  // Compare and count
  task automatic chk(input logic [31:0] g, input logic [31:0] x, input string m);
    checks++;
    if (g !== x) begin
      errors++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : chk
  // One APB transfer, held until pready; only the hang guard ends a wait
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge sys_clk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin @(posedge sys_clk); end while (pready !== 1'b1);
    r = prdata; e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r; logic e;
    apb(1'b1, a, d, r, e);
    chk(32'(e), 0, "write error");
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] x, input string m);
    logic [31:0] r; logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, x, m);
  endtask : rd
  // Raise an underflow, return how long the pin was driven
  task automatic wdg_hit(output int n);
    int k;
    wdg_underflow <= 1'b1;
    @(posedge sys_clk);
    wdg_underflow <= 1'b0;
    k = 0; n = 0;
    while (rst_pin_oe_n !== 1'b0 && k < 5) begin @(posedge sys_clk); k++; end
    while (rst_pin_oe_n === 1'b0 && n < 3000) begin @(posedge sys_clk); n++; end
  endtask : wdg_hit
  ////////////////////////////////////////////////////////////
  task automatic t_regs;
    logic [31:0] r; logic e;
    rd(A_TH, 32'h3, "thresh reset");
    rd(A_OP, 32'h1, "option reset");
    rd(A_MK, 32'h0, "mask reset");
    chk(32'(warn_det_enable), 0, "detector on at reset");
    apb(1'b0, 12'h020, 32'h0, r, e);
    chk(32'(e), 1, "unmapped no error");
    chk(r, 0, "unmapped data");
    $display("t_regs done");
  endtask : t_regs
  task automatic t_thresh;
    for (int i = 0; i < 4; i++) begin
      wr(A_TH, 32'(i));
      rd(A_TH, 32'(i), "thresh readback");
      chk(32'(warn_thresh_sel), 32'(i), "thresh select out");
      chk(32'(warn_det_enable), 32'(i != 3), "detector enable");
    end
    $display("t_thresh done");
  endtask : t_thresh
  task automatic t_warn;
    wr(A_TH, 32'h0); wr(A_MK, 32'h1); wr(A_ST, 32'h1);
    ana.warn_low <= 1'b1;
    repeat (60) @(posedge sys_clk);
    rd(A_ST, 32'h3, "warn flag not live");
    chk(32'(warn_irq_req), 1, "no falling request");
    chk(32'(irq), 1, "irq not raised");
    cpu_mode <= sirm_pkg::SIRM_WAIT;
    repeat (3) @(posedge sys_clk);
    chk(32'(warn_wake), 1, "no wake from wait");
    cpu_mode <= sirm_pkg::SIRM_HALT;
    wr(A_ST, 32'h0);
    rd(A_ST, 32'h3, "status not frozen");
    rd(A_CP, 32'hC, "cpu view in halt");
    chk(32'(warn_wake), 0, "wake from halt");
    cpu_mode <= sirm_pkg::SIRM_RUN;
    cpu_irq_mask <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk(32'(warn_irq_req), 0, "request while masked");
    cpu_irq_mask <= 1'b0; warn_isr_enter <= 1'b1;
    @(posedge sys_clk);
    warn_isr_enter <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk(32'(warn_irq_req), 0, "not cleared on entry");
    wr(A_EV, 32'h1);
    repeat (2) @(posedge sys_clk);
    chk(32'(irq), 0, "event not cleared");
    ana.warn_low <= 1'b0;
    repeat (60) @(posedge sys_clk);
    chk(32'(warn_irq_req), 1, "no rising request");
    wr(A_ST, 32'h3);
    rd(A_ST, 32'h1, "warn flag writable");
    warn_isr_enter <= 1'b1;
    wr(A_EV, 32'h1); wr(A_ST, 32'h0);
    warn_isr_enter <= 1'b0;
    $display("t_warn done");
  endtask : t_warn
  task automatic t_wdg;
    int n;
    wdg_hit(n);
    chk(32'(n >= `SIRM_WDG_PULSE_CYC), 1, "watchdog pulse short");
    rd(A_ST, 32'h10, "watchdog flag not set");
    wr(A_ST, 32'h0);
    rd(A_ST, 32'h0, "watchdog flag not cleared");
    wdg_hit(n);
    chk(32'(n >= `SIRM_WDG_PULSE_CYC), 1, "second watchdog pulse short");
    $display("t_wdg done");
  endtask : t_wdg
  task automatic t_uv;
    int lows;
    ana.uv_low <= 1'b1;
    repeat (100) @(posedge sys_clk);
    chk(32'(pin_n), 0, "pin not low in undervoltage");
    chk(32'(sys_reset), 1, "no system reset");
    ana.uv_low <= 1'b0;
    repeat (60) @(posedge sys_clk);
    chk(32'(rst_pin_oe_n), 1, "pin not released");
    rd(A_ST, 32'h4, "reset source flags");
    rd(A_ST, 32'h0, "uv flag not read-cleared");
    rd(A_EV, 32'hE, "event status");
    wr(A_EV, 32'hE);
    rd(A_EV, 32'h0, "event status not cleared");
    lows = 0;
    ana.uv_low <= 1'b1;
    for (int i = 0; i < 60; i++) begin
      @(posedge sys_clk);
      if (i == 9) ana.uv_low <= 1'b0;
      if (rst_pin_oe_n !== 1'b1) lows++;
    end
    chk(32'(lows), 0, "spike reset");
    for (int l = 0; l < 3; l++) begin
      wr(A_OP, 32'(l * 2 + 1));
      repeat (2) @(posedge sys_clk);
      chk(32'(uv_thresh_sel), 32'(l), "uv level select");
    end
    wr(A_OP, 32'h0);
    ana.uv_low <= 1'b1;
    repeat (100) @(posedge sys_clk);
    chk(32'(rst_pin_oe_n), 1, "disabled detector reset");
    chk(32'(sys_reset), 0, "disabled detector system reset");
    ana.uv_low <= 1'b0;
    repeat (60) @(posedge sys_clk);
    wr(A_OP, 32'h1);
    $display("t_uv done");
  endtask : t_uv
  task automatic t_pin;
    ext_low <= 1'b1;
    repeat (60) @(posedge sys_clk);
    chk(32'(sys_reset), 1, "pin reset missed");
    ext_low <= 1'b0;
    repeat (60) @(posedge sys_clk);
    chk(32'(sys_reset), 0, "pin reset stuck");
    $display("t_pin done");
  endtask : t_pin
  ////////////////////////////////////////////////////////////
  // Hang guard
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      end_sim();
    end
  end
  // Main sequence
  initial begin
    repeat (6) @(posedge sys_clk);
    reset <= 1'b0;
    t_regs(); t_thresh(); t_warn(); t_wdg(); t_uv(); t_pin();
    end_sim();
  end
endmodule : testbench
`default_nettype wire
